/* File: rtl/sarcc_top.sv */
/*
 * Conversion control for a 10-bit successive-approximation converter.
 * Assumes synchronous trigger inputs and comparator, and an AXI4-Lite master.
 */
`timescale 1ns/1ps
`default_nettype none

module sarcc_top
   import sarcc_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write channels
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read channels
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Start sources and power state
   input wire sarcc_trig_t trig,
   input wire logic standby_req,
   // Analog front end
   input wire logic cmp_above,
   output sarcc_mux_t mux_sel,
   output sarcc_sar_t sar_ctl,
   // Completion interrupt
   output logic done_irq
);
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic sarcc_mapped(input logic [7:0] a);
      logic m;
      m = (a == CTRL_OFS) || (a == CFG_OFS) || (a == PSEL_OFS) ||
          (a == NSEL_OFS) || (a == RES_OFS) || (a == STAT_OFS);
      return m;
   endfunction : sarcc_mapped

   function automatic logic [15:0] sarcc_format(input logic [9:0] code, input logic diff, input logic lj);
      logic [15:0] f;
      if (lj) begin
         f = {code, 6'h00};
      end else if (diff) begin
         f = {{6{code[9]}}, code};
      end else begin
         f = {6'h00, code};
      end
      return f;
   endfunction : sarcc_format

   function automatic logic sarcc_hit(input sarcc_src_t src, input sarcc_trig_t t, input logic sw,
                                      input logic er);
      logic h;
      case (src)
         SRC_SW: h = sw;
         SRC_T0: h = t.t0_ovf;
         SRC_T2: h = t.t2_16bit ? t.t2_high_ovf : t.t2_low_ovf;
         SRC_T1: h = t.t1_ovf;
         SRC_EXT: h = er;
         SRC_T3: h = t.t3_16bit ? t.t3_high_ovf : t.t3_low_ovf;
         default: h = 1'b0;
      endcase
      return h;
   endfunction : sarcc_hit

   sarcc_regs_t s_r;
   sarcc_regs_t s_nxt;
   logic wr_go;
   logic [7:0] wb;
   logic sw_start;
   logic clr_flag;
   logic start;
   logic tick;
   logic ext_rise;
   logic done;
   logic [9:0] mask;
   logic [9:0] keep;
   logic [9:0] raw;

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      s_nxt = s_r;
      wr_go = 1'b0;
      wb = 8'h00;
      sw_start = 1'b0;
      clr_flag = 1'b0;
      done = 1'b0;
      // Write address and data may arrive in either order
      if (s_axi_awvalid && s_r.awready) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_r.wready) begin
         s_nxt.w_got = 1'b1;
         s_nxt.wdata = s_axi_wdata;
         s_nxt.wstrb = s_axi_wstrb;
      end
      if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
      end
      wr_go = s_nxt.aw_got && s_nxt.w_got && !s_nxt.bvalid;
      wb = s_nxt.wdata[7:0];
      if (wr_go) begin
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = sarcc_mapped(s_nxt.aw_addr) ? RESP_OKAY : RESP_SLVERR;
         if (s_nxt.wstrb[0]) begin
            case (s_nxt.aw_addr)
               CTRL_OFS: begin
                  s_nxt.en = wb[CTRL_EN_BIT];
                  s_nxt.tm = wb[CTRL_TM_BIT];
                  s_nxt.src = sarcc_src_t'(wb[CTRL_SRC_LSB+:3]);
                  s_nxt.ie = wb[CTRL_IE_BIT];
                  clr_flag = wb[CTRL_FLAG_BIT];
                  sw_start = wb[CTRL_BUSY_BIT];
               end
               CFG_OFS: begin
                  s_nxt.div = wb[CFG_DIV_LSB+:5];
                  s_nxt.lj = wb[CFG_LJ_BIT];
               end
               PSEL_OFS: s_nxt.mux.pos_code = wb[4:0];
               NSEL_OFS: s_nxt.mux.neg_code = wb[4:0];
               default: ;
            endcase
         end
      end
      s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
      s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;
      // Read channel
      if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_r.arready) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = sarcc_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         case (s_axi_araddr)
            CTRL_OFS: s_nxt.rdata = {24'h0, s_r.ie, s_r.flag, s_r.busy, s_r.src, s_r.tm, s_r.en};
            CFG_OFS: s_nxt.rdata = {24'h0, s_r.div, s_r.lj, 2'h0};
            PSEL_OFS: s_nxt.rdata = {27'h0, s_r.mux.pos_code};
            NSEL_OFS: s_nxt.rdata = {27'h0, s_r.mux.neg_code};
            RES_OFS: s_nxt.rdata = {16'h0, s_r.result};
            STAT_OFS: s_nxt.rdata = {29'h0, s_r.sar_out.hold, s_r.sar_out.track, s_r.mux.single_ended};
            default: s_nxt.rdata = 32'h0;
         endcase
      end
      s_nxt.arready = !s_nxt.rvalid;
      // Conversion clock divider
      tick = s_r.div_cnt >= s_r.div;
      s_nxt.div_cnt = tick ? 5'h00 : 5'(s_r.div_cnt + 5'h01);
      ext_rise = trig.ext_start && !s_r.ext_prev;
      s_nxt.ext_prev = trig.ext_start;
      start = s_r.en && sarcc_hit(s_r.src, trig, sw_start, ext_rise);
      // Successive approximation step
      mask = 10'(10'h001 << s_r.bit_idx);
      keep = cmp_above ? s_r.sar : (s_r.sar & ~mask);
      raw = s_r.mux.single_ended ? keep : (keep ^ SAR_MSB);
      case (s_r.fsm)
         ST_IDLE: begin
            if (start) begin
               if (s_r.tm && (s_r.src != SRC_EXT)) begin
                  s_nxt.fsm = ST_TRACK;
                  s_nxt.trk_cnt = 2'h0;
               end else begin
                  s_nxt.fsm = ST_CONV;
                  s_nxt.sar = SAR_MSB;
                  s_nxt.bit_idx = SAR_TOP_IDX;
               end
            end
         end
         ST_TRACK: begin
            if (tick) begin
               if (s_r.trk_cnt == TRACK_LAST) begin
                  s_nxt.fsm = ST_CONV;
                  s_nxt.sar = SAR_MSB;
                  s_nxt.bit_idx = SAR_TOP_IDX;
               end else begin
                  s_nxt.trk_cnt = 2'(s_r.trk_cnt + 2'h1);
               end
            end
         end
         ST_CONV: begin
            if (tick) begin
               if (s_r.bit_idx == 4'h0) begin
                  s_nxt.fsm = ST_IDLE;
                  s_nxt.result = sarcc_format(raw, !s_r.mux.single_ended, s_r.lj);
                  done = 1'b1;
               end else begin
                  s_nxt.sar = keep | (mask >> 1);
                  s_nxt.bit_idx = 4'(s_r.bit_idx - 4'h1);
               end
            end
         end
         default: s_nxt.fsm = ST_IDLE;
      endcase
      if (!s_nxt.en) begin
         s_nxt.fsm = ST_IDLE;
      end
      s_nxt.busy = s_nxt.fsm != ST_IDLE;
      // Completion flag: a completion in the clearing cycle wins
      if (clr_flag) begin
         s_nxt.flag = 1'b0;
      end
      if (done) begin
         s_nxt.flag = 1'b1;
      end
      s_nxt.irq = s_nxt.flag && s_nxt.ie;
      // Input routing
      s_nxt.mux.single_ended = s_nxt.mux.neg_code == NEG_GND;
      s_nxt.mux.temp_sel = s_nxt.mux.pos_code == POS_TEMP;
      s_nxt.mux.supply_sel = s_nxt.mux.pos_code == POS_SUPPLY;
      s_nxt.mux.ref_sel = s_nxt.mux.neg_code == NEG_REF;
      // Track and hold control
      if (!s_nxt.en || standby_req) begin
         s_nxt.sar_out.track = 1'b0;
      end else if (s_nxt.tm) begin
         s_nxt.sar_out.track = (s_nxt.fsm == ST_TRACK) ||
            ((s_nxt.fsm == ST_IDLE) && (s_nxt.src == SRC_EXT) && !trig.ext_start);
      end else begin
         s_nxt.sar_out.track = s_nxt.fsm != ST_CONV;
      end
      s_nxt.sar_out.hold = s_nxt.fsm == ST_CONV;
      s_nxt.sar_out.trial = s_nxt.sar;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= SARCC_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign s_axi_awready = s_r.awready;
   assign s_axi_wready = s_r.wready;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_arready = s_r.arready;
   assign s_axi_rdata = s_r.rdata;
   assign s_axi_rresp = s_r.rresp;
   assign s_axi_rvalid = s_r.rvalid;
   assign mux_sel = s_r.mux;
   assign sar_ctl = s_r.sar_out;
   assign done_irq = s_r.irq;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   logic [5:0] gap_r;
   logic div_chg_r;
   logic seen_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gap_r <= 6'h00;
         div_chg_r <= 1'b0;
         seen_r <= 1'b0;
      end else begin
         gap_r <= tick ? 6'h00 : 6'(gap_r + 6'h01);
         div_chg_r <= tick ? 1'b0 : (div_chg_r || (s_nxt.div != s_r.div));
         seen_r <= seen_r || tick;
      end
   end

   sequence conv_end_s;
      (s_r.fsm == ST_CONV) ##1 (s_r.fsm == ST_IDLE) && s_r.en;
   endsequence
   sequence track_exit_s;
      (s_r.fsm == ST_TRACK) ##1 (s_r.fsm == ST_CONV);
   endsequence
   sequence cont_start_s;
      (s_r.fsm == ST_IDLE) && start && !s_r.tm && s_nxt.en;
   endsequence

   single_mode_a: assert property (s_r.mux.single_ended == (s_r.mux.neg_code == NEG_GND))
      else $error("single-ended mode does not follow negative select");
   route_temp_a: assert property (s_r.mux.temp_sel == (s_r.mux.pos_code == POS_TEMP))
      else $error("temperature route wrong");
   done_flag_a: assert property (conv_end_s |-> s_r.flag && $changed(s_r.busy))
      else $error("completion flag not set at end of conversion");
   irq_follow_a: assert property (s_r.flag && s_r.ie |-> s_r.irq)
      else $error("enabled completion not requesting interrupt");
   se_zero_a: assert property ($rose(s_r.flag) && s_r.mux.single_ended && !s_r.lj |->
      s_r.result[15:10] == 6'h00)
      else $error("single-ended unused high bits not zero");
   lj_low_a: assert property ($rose(s_r.flag) && s_r.lj |-> s_r.result[5:0] == 6'h00)
      else $error("left-justified low bits not zero");
   sign_ext_a: assert property ($rose(s_r.flag) && !s_r.mux.single_ended && !s_r.lj |->
      s_r.result[15:10] == {6{s_r.result[9]}})
      else $error("differential result not sign-extended");
   track_three_a: assert property (track_exit_s |-> $past(s_r.trk_cnt) == TRACK_LAST)
      else $error("tracking period not three conversion clocks");
   div_gap_a: assert property (tick && seen_r && !div_chg_r |-> gap_r == {1'b0, s_r.div})
      else $error("conversion clock period wrong");
   conv_hold_a: assert property ((s_r.fsm == ST_CONV) && !tick && s_nxt.en |=>
      (s_r.fsm == ST_CONV) && $stable(s_r.bit_idx))
      else $error("conversion disturbed by trigger");
   sw_start_a: assert property (wr_go && sw_start && (s_r.src == SRC_SW) && s_r.en &&
      (s_r.fsm == ST_IDLE) && s_nxt.en |=> s_r.busy[*2])
      else $error("software start did not raise active bit");
   t2_wide_a: assert property ((s_r.fsm == ST_IDLE) && s_r.en && s_nxt.en && !s_r.tm &&
      (s_r.src == SRC_T2) && trig.t2_16bit && trig.t2_high_ovf |=> s_r.fsm == ST_CONV)
      else $error("timer 2 high overflow did not start");
   no_track_conv_a: assert property (s_r.sar_out.hold |-> !s_r.sar_out.track)
      else $error("tracking during conversion");
   standby_a: assert property ($past(standby_req) |-> !s_r.sar_out.track)
      else $error("tracking during standby");
   ext_rise_a: assert property ((s_r.fsm == ST_IDLE) && s_r.en && s_nxt.en && s_r.tm &&
      (s_r.src == SRC_EXT) && ext_rise |=> s_r.fsm == ST_CONV)
      else $error("external rising edge did not start conversion");
   off_idle_a: assert property (!s_nxt.en |=> (s_r.fsm == ST_IDLE) && !s_r.sar_out.track)
      else $error("disabled converter not shut down");
   route_ref_a: assert property ((s_r.mux.ref_sel == (s_r.mux.neg_code == NEG_REF)) &&
      (s_r.mux.supply_sel == (s_r.mux.pos_code == POS_SUPPLY)))
      else $error("reference or supply route wrong");
   place_left_a: assert property (done && s_r.lj |=> s_r.result[15:6] == $past(raw))
      else $error("left-justified code misplaced");
   place_right_a: assert property (done && !s_r.lj |=>
      s_r.result[9:0] == $past(raw))
      else $error("right-justified code misplaced");
   result_keep_a: assert property (!done |=> $stable(s_r.result))
      else $error("result changed without completion");
   busy_fall_a: assert property ($fell(s_r.busy) && s_r.en |-> s_r.flag)
      else $error("active bit fell without setting flag");
   cont_conv_a: assert property (cont_start_s |=> (s_r.fsm == ST_CONV) && s_r.busy)
      else $error("continuous tracking start did not convert");
endmodule : sarcc_top

`default_nettype wire

/* File: rtl/sarcc_pkg.sv */
/*
 * Shared constants and types for the converter control block.
 * Assumes a single 200 MHz clock domain and a 32-bit AXI4-Lite register bus.
 */
package sarcc_pkg;
   // ****************************************
   // Register map and fields
   // ****************************************
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] CFG_OFS = 8'h04;
   localparam logic [7:0] PSEL_OFS = 8'h08;
   localparam logic [7:0] NSEL_OFS = 8'h0c;
   localparam logic [7:0] RES_OFS = 8'h10;
   localparam logic [7:0] STAT_OFS = 8'h14;
   localparam int unsigned CTRL_EN_BIT = 0;
   localparam int unsigned CTRL_TM_BIT = 1;
   localparam int unsigned CTRL_SRC_LSB = 2;
   localparam int unsigned CTRL_BUSY_BIT = 5;
   localparam int unsigned CTRL_FLAG_BIT = 6;
   localparam int unsigned CTRL_IE_BIT = 7;
   localparam int unsigned CFG_LJ_BIT = 2;
   localparam int unsigned CFG_DIV_LSB = 3;
   localparam logic [4:0] CFG_DIV_RST = 5'h1f;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ****************************************
   // Converter constants
   // ****************************************
   localparam logic [4:0] POS_TEMP = 5'h1e;
   localparam logic [4:0] POS_SUPPLY = 5'h1f;
   localparam logic [4:0] NEG_REF = 5'h1e;
   localparam logic [4:0] NEG_GND = 5'h1f;
   localparam logic [9:0] SAR_MSB = 10'h200;
   localparam logic [3:0] SAR_TOP_IDX = 4'h9;
   localparam logic [1:0] TRACK_LAST = 2'h2;
   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [2:0] {
      SRC_SW = 3'h0, SRC_T0 = 3'h1, SRC_T2 = 3'h2, SRC_T1 = 3'h3, SRC_EXT = 3'h4, SRC_T3 = 3'h5
   } sarcc_src_t;
   typedef enum logic [2:0] {ST_IDLE = 3'h1, ST_TRACK = 3'h2, ST_CONV = 3'h4} sarcc_state_t;
   typedef struct packed {
      logic t0_ovf;
      logic t1_ovf;
      logic t2_low_ovf;
      logic t2_high_ovf;
      logic t2_16bit;
      logic t3_low_ovf;
      logic t3_high_ovf;
      logic t3_16bit;
      logic ext_start;
   } sarcc_trig_t;
   typedef struct packed {
      logic [4:0] pos_code;
      logic [4:0] neg_code;
      logic single_ended;
      logic temp_sel;
      logic supply_sel;
      logic ref_sel;
   } sarcc_mux_t;
   typedef struct packed {
      logic track;
      logic hold;
      logic [9:0] trial;
   } sarcc_sar_t;
   typedef struct packed {
      sarcc_state_t fsm;
      logic en;
      logic tm;
      logic ie;
      sarcc_src_t src;
      logic flag;
      logic busy;
      logic [4:0] div;
      logic lj;
      logic [15:0] result;
      logic [4:0] div_cnt;
      logic [1:0] trk_cnt;
      logic [3:0] bit_idx;
      logic [9:0] sar;
      logic ext_prev;
      logic irq;
      logic aw_got;
      logic w_got;
      logic [7:0] aw_addr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      sarcc_mux_t mux;
      sarcc_sar_t sar_out;
   } sarcc_regs_t;
   localparam sarcc_regs_t SARCC_RST = '{fsm: ST_IDLE, src: SRC_SW, div: CFG_DIV_RST, default: '0};
endpackage : sarcc_pkg

/* File: verif/sarcc_partner.sv */
/*
 * Far-side model: timer and start-pin triggers, and the comparator.
 * Assumes the caller enters fire() and mode() just after a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module sarcc_partner
   import sarcc_pkg::*;
(
   // Clock
   input wire logic aclk,
   // Converter side
   input wire sarcc_sar_t sar_ctl,
   output logic cmp_above,
   output sarcc_trig_t trig
);
   // ****************************************
   // Analog level and start sources
   // ****************************************
   logic [9:0] level = 10'h000;
   initial trig = '0;
   // Comparator judges the level against the present trial code
   assign cmp_above = level >= sar_ctl.trial;
   // One-cycle pulse on a trigger line; line 0 gives a rising pin edge
   task automatic fire(input int idx);
      trig[idx] <= 1'b1;
      @(posedge aclk);
      trig[idx] <= 1'b0;
   endtask : fire
   // Timer widths: 1 selects the 16-bit mode
   task automatic mode(input logic t2, input logic t3);
      trig.t2_16bit <= t2;
      trig.t3_16bit <= t3;
   endtask : mode
endmodule : sarcc_partner
`default_nettype wire

/* File: verif/sarcc_bench.sv */
/*
 * Self-checking bench for the converter control block.
 * Assumes sarcc_top, sarcc_partner and one 200 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module sarcc_bench
   import sarcc_pkg::*;
;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = '0, araddr = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = '0;
   logic standby = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, cmp, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   sarcc_trig_t trig;
   sarcc_mux_t mux;
   sarcc_sar_t sar;
   int errors = 0, checks = 0, nh = 0, nt = 0, bad = 0;
   logic [15:0] lf = 16'h0003;
   // Trigger lines by tracking mode; timers run 16-bit while tracking mode is off
   int rt[2][6] = '{'{0, 8, 5, 7, 0, 2}, '{0, 8, 6, 7, 0, 3}};
   int wr[2][6] = '{'{8, 7, 6, 8, 8, 3}, '{8, 7, 5, 8, 8, 2}};
   initial forever #2.5 aclk = ~aclk;
   sarcc_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .trig(trig),
      .standby_req(standby), .cmp_above(cmp), .mux_sel(mux), .sar_ctl(sar), .done_irq(irq));
   sarcc_partner P (.aclk(aclk), .sar_ctl(sar), .cmp_above(cmp), .trig(trig));
   // ****************************************
   // Monitor, model and bus tasks
   // ****************************************
   always @(posedge aclk) begin
      nh <= nh + int'(sar.hold);
      nt <= nt + int'(sar.track && !sar.hold);
      bad <= bad + int'(sar.track && sar.hold);
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   function automatic logic [15:0] model(input logic [9:0] lv, input logic se, input logic lj);
      logic [9:0] c;
      c = se ? lv : lv ^ 10'h200;
      if (lj) return {c, 6'h00};
      return se ? {6'h00, c} : {{6{c[9]}}, c};
   endfunction : model
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask : axw
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axr
   task automatic wait_done(output logic [31:0] d);
      logic [1:0] r;
      for (int n = 0; n < 100; n++) begin
         axr(CTRL_OFS, d, r);
         if (d[6] === 1'b1) break;
      end
   endtask : wait_done
   task automatic summarize;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : summarize
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      #200000;
      errors++;
      summarize();
   end
   initial begin
      logic [31:0] d, c;
      logic [1:0] r;
      logic [9:0] lv;
      logic [4:0] ps, ng;
      logic lj, se, m, ie;
      logic [7:0] ofs[4];
      int src, h0, t0;
      ofs = '{PSEL_OFS, NSEL_OFS, RES_OFS, CTRL_OFS};
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      axw(RES_OFS, 32'hffff, r);
      chk("ro_resp", r, RESP_OKAY);
      foreach (ofs[k]) begin
         axr(ofs[k], d, r);
         chk("reg_rst", d, 32'h0);
      end
      axr(CFG_OFS, d, r);
      chk("cfg_rst", d, 32'hf8);
      axr(8'h18, d, r);
      chk("unmapped", {d[29:0], r}, {30'h0, RESP_SLVERR});
      axw(CTRL_OFS, 32'h20, r);
      repeat (4) @(posedge aclk);
      chk("off_hold", sar.hold, 1'b0);
      axw(CTRL_OFS, 32'h01, r);
      chk("idle_trk", sar.track, 1'b1);
      standby <= 1'b1;
      repeat (3) @(posedge aclk);
      chk("standby", sar.track, 1'b0);
      standby <= 1'b0;
      $display("test setup done");
      for (int i = 0; i < 12; i++) begin
         src = i % 6;
         m = i >= 6;
         lj = i[0];
         se = !i[1];
         ie = i[2];
         lv = i < 4 ? 10'h3ff : i < 7 ? 10'h000 : lf[9:0];
         lf = lfsr(lf);
         ps = i == 0 || i == 2 ? POS_TEMP : i == 3 ? POS_SUPPLY : lf[4:0];
         ng = se ? NEG_GND : i[2] ? NEG_REF : 5'h05;
         P.level <= lv;
         P.mode(!m, !m);
         axw(PSEL_OFS, {27'h0, ps}, r);
         axw(NSEL_OFS, {27'h0, ng}, r);
         axw(CFG_OFS, {24'h0, 5'h03, lj, 2'h0}, r);
         chk("single_ended", mux.single_ended, se);
         chk("mux_sel", {mux.temp_sel, mux.supply_sel, mux.ref_sel},
             {ps == 5'h1e, ps == 5'h1f, ng == 5'h1e});
         chk("codes", {mux.pos_code, mux.neg_code}, {ps, ng});
         c = {24'h0, ie, 2'h0, src[2:0], m, 1'b1};
         axw(CTRL_OFS, c, r);
         chk("idle_track", sar.track, !m || src == 4);
         axr(STAT_OFS, d, r);
         chk("status", d, {29'h0, 1'b0, !m || src == 4, se});
         P.fire(wr[m][src]);
         repeat (4) @(posedge aclk);
         chk("other_src", {sar.hold, sar.track}, {1'b0, !m || src == 4});
         h0 = nh;
         t0 = nt;
         if (src == 0) begin
            axw(CTRL_OFS, c | 32'h20, r);
         end else begin
            P.fire(rt[m][src]);
            repeat (12) @(posedge aclk);
            P.fire(rt[m][src]);
         end
         wait_done(d);
         chk("hold_len", nh - h0 >= 37 && nh - h0 <= 40, 1'b1);
         if (m && src != 4) chk("track_len", nt - t0 >= 9 && nt - t0 <= 12, 1'b1);
         chk("overlap", bad, 0);
         chk("busy_flag", d[6:5], 2'b10);
         chk("irq", irq, ie);
         axr(RES_OFS, d, r);
         chk("result", d, {16'h0, model(lv, se, lj)});
         axw(CTRL_OFS, c | 32'h40, r);
         axr(CTRL_OFS, d, r);
         chk("flag_clr", {d[6], irq}, 2'b00);
         $display("test %0d done", i);
      end
      summarize();
   end
endmodule : sarcc_bench
`default_nettype wire
